// ==== hw/fei_pkg.sv ====
// Constants shared by the flash event interrupt unit
package fei_pkg;
   localparam int          DATA_W        = 16;
   localparam int          ADDR_W        = 4;
   localparam int          SYS_W         = 2;

   // Register addresses on the plain register port
   localparam logic [3:0]  ADDR_CFG      = 4'h0;
   localparam logic [3:0]  ADDR_FLAGS    = 4'h1;
   localparam logic [3:0]  ADDR_SYS_ST   = 4'h2;
   localparam logic [3:0]  ADDR_SYS_MASK = 4'h3;

   // Field positions in event_enable_config and event_occurred_flags
   localparam int          BIT_OUT_EN    = 15;
   localparam int          BIT_READY     = 4;
   localparam int          BIT_POR       = 2;
   localparam int          BIT_ECC2      = 1;
   localparam int          BIT_ECC1      = 0;

   // Sources that can pull the pin low
   localparam logic [15:0] SRC_MASK      = 16'h0013;
   // Bits of event_enable_config that software can change
   localparam logic [15:0] CFG_WR_MASK   = 16'h8013;
   // Bits of event_occurred_flags that a write of one restores
   localparam logic [15:0] FLAGS_WR_MASK = 16'h0017;

   // Reset values
   localparam logic [15:0] CFG_RST       = 16'hFFFF;
   localparam logic [15:0] FLAGS_HW_RST  = 16'hFFFF;
   localparam logic [15:0] FLAGS_POR_RST = 16'hFFFB;
   localparam logic [1:0]  SYS_RST       = 2'h0;
   localparam logic [1:0]  SYS_MASK_RST  = 2'h0;

   // System status bits
   localparam int          SYS_INT_ASSERT = 0;
   localparam int          SYS_POR_SEEN   = 1;
endpackage

// ==== hw/fei_top.sv ====
// Flash event interrupt unit: event flags, enables and open-drain pin
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
module fei_top (
   input  wire logic        REF_CLK,
   input  wire logic        RST_N,
   input  wire logic        POR_N,
   input  wire logic        EVT_READY,
   input  wire logic        EVT_ECC2,
   input  wire logic        EVT_ECC1,
   input  wire logic [3:0]  ADDR,
   input  wire logic [15:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [15:0] RDATA,
   output logic             INT_O,
   output logic             INT_OE_N,
   output logic             IRQ
);

   function automatic logic addr_hit(input logic [3:0] a,
                                     input logic [3:0] off);
      addr_hit = (a == off);
   endfunction

   logic [15:0] cfg_reg;
   logic [15:0] cfg_next;
   logic [15:0] flags_reg;
   logic [15:0] flags_next;
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;
   logic        drive_reg;
   logic        drive_next;
   logic        int_o_reg;
   logic [1:0]  sys_reg;
   logic [1:0]  sys_next;
   logic [1:0]  mask_reg;
   logic [1:0]  mask_next;
   logic        irq_reg;
   logic        irq_next;
   logic        por_meta_reg;
   logic        por_sync_reg;
   logic        por_act;
   logic        cfg_wr;
   logic        flags_wr;
   logic [15:0] evt_vec;
   logic [15:0] capture;
   logic [15:0] pending;

   // Power-on detector arrives from another domain, so it is synchronised
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         por_meta_reg <= 1'b1;
         por_sync_reg <= 1'b1;
      end else begin
         por_meta_reg <= POR_N;
         por_sync_reg <= por_meta_reg;
      end
   end

   assign por_act = !por_sync_reg;

   always_comb begin
      evt_vec = '0;
      evt_vec[fei_pkg::BIT_READY] = EVT_READY;
      evt_vec[fei_pkg::BIT_ECC2]  = EVT_ECC2;
      evt_vec[fei_pkg::BIT_ECC1]  = EVT_ECC1;
      cfg_wr     = WR && addr_hit(ADDR, fei_pkg::ADDR_CFG);
      flags_wr   = WR && addr_hit(ADDR, fei_pkg::ADDR_FLAGS);
      cfg_next   = cfg_reg;
      flags_next = flags_reg;
      mask_next  = mask_reg;
      if (cfg_wr) begin
         // Reserved config bits stay at one whatever is written
         cfg_next   = WDATA | ~fei_pkg::CFG_WR_MASK;
         flags_next = flags_next | (WDATA & fei_pkg::SRC_MASK);
         if (WDATA[fei_pkg::BIT_OUT_EN]) begin
            flags_next = fei_pkg::FLAGS_HW_RST;
         end
      end
      if (flags_wr) begin
         // Writes can only raise flags
         flags_next = flags_next | (WDATA & fei_pkg::FLAGS_WR_MASK);
      end
      // An event beats a clear in the same cycle, but only on a source
      // that stays enabled after this cycle's config write
      capture    = evt_vec & ~cfg_next & fei_pkg::SRC_MASK;
      flags_next = flags_next & ~capture;
      if (WR && addr_hit(ADDR, fei_pkg::ADDR_SYS_MASK)) begin
         mask_next = WDATA[1:0];
      end
      // Power-on flag is outside the source mask so it never reaches the pin
      pending    = ~flags_reg & ~cfg_reg & fei_pkg::SRC_MASK;
      drive_next = !cfg_reg[fei_pkg::BIT_OUT_EN] && (|pending);
      if (por_act) begin
         cfg_next   = fei_pkg::CFG_RST;
         flags_next = fei_pkg::FLAGS_POR_RST;
         drive_next = 1'b0;
      end
   end

   // Sticky system status; read clears, a new event in that cycle wins
   always_comb begin
      sys_next = sys_reg;
      if (RD && addr_hit(ADDR, fei_pkg::ADDR_SYS_ST)) begin
         sys_next = fei_pkg::SYS_RST;
      end
      if (drive_next && !drive_reg) begin
         sys_next[fei_pkg::SYS_INT_ASSERT] = 1'b1;
      end
      if (por_act) begin
         sys_next[fei_pkg::SYS_POR_SEEN] = 1'b1;
      end
      irq_next = |(sys_next & mask_next);
   end

   always_comb begin
      rdata_next = '0;
      if (RD) begin
         case (ADDR)
            fei_pkg::ADDR_CFG:      rdata_next = cfg_reg;
            fei_pkg::ADDR_FLAGS:    rdata_next = flags_reg;
            fei_pkg::ADDR_SYS_ST:   rdata_next = {14'h0000, sys_reg};
            fei_pkg::ADDR_SYS_MASK: rdata_next = {14'h0000, mask_reg};
            default:                rdata_next = '0;
         endcase
      end
   end

   // Hardware reset restores every register, power-on flag included
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         cfg_reg   <= fei_pkg::CFG_RST;
         flags_reg <= fei_pkg::FLAGS_HW_RST;
         drive_reg <= 1'b0;
         int_o_reg <= 1'b0;
         sys_reg   <= fei_pkg::SYS_RST;
         mask_reg  <= fei_pkg::SYS_MASK_RST;
         irq_reg   <= 1'b0;
         rdata_reg <= '0;
      end else begin
         cfg_reg   <= cfg_next;
         flags_reg <= flags_next;
         drive_reg <= drive_next;
         int_o_reg <= 1'b0;
         sys_reg   <= sys_next;
         mask_reg  <= mask_next;
         irq_reg   <= irq_next;
         rdata_reg <= rdata_next;
      end
   end

   // Pin level is always low; only the enable moves, so the pull-up
   // gives the released level
   assign INT_O    = int_o_reg;
   assign INT_OE_N = !drive_reg;
   assign IRQ      = irq_reg;
   assign RDATA    = rdata_reg;

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);

   logic any_evt;
   assign any_evt = EVT_READY || EVT_ECC2 || EVT_ECC1;

   sequence s_out_off_write;
      cfg_wr && WDATA[fei_pkg::BIT_OUT_EN] && !any_evt && !por_act;
   endsequence

   sequence s_pending_on;
      !cfg_reg[fei_pkg::BIT_OUT_EN] && (|pending) && !por_act;
   endsequence

   sequence s_quiet;
      !cfg_wr && !flags_wr && !por_act;
   endsequence

   chk_out_disable: assert property (
      cfg_reg[fei_pkg::BIT_OUT_EN] |=> INT_OE_N)
      else $error("pin driven while output disabled");

   chk_out_off_clear: assert property (
      s_out_off_write |=> flags_reg == fei_pkg::FLAGS_HW_RST)
      else $error("flags not restored by output disable");

   chk_ready_capture: assert property (
      (EVT_READY && !cfg_reg[fei_pkg::BIT_READY]) and s_quiet
      |=> !flags_reg[fei_pkg::BIT_READY])
      else $error("ready event not captured");

   chk_ecc2_capture: assert property (
      (EVT_ECC2 && !cfg_reg[fei_pkg::BIT_ECC2]) and s_quiet
      |=> !flags_reg[fei_pkg::BIT_ECC2] ##1 !INT_OE_N
          || cfg_reg[fei_pkg::BIT_OUT_EN])
      else $error("two-bit event not captured");

   chk_ecc1_ignored: assert property (
      cfg_reg[fei_pkg::BIT_ECC1] and s_quiet
      |=> flags_reg[fei_pkg::BIT_ECC1] == $past(flags_reg[fei_pkg::BIT_ECC1]))
      else $error("disabled one-bit source changed its flag");

   chk_src_disable: assert property (
      cfg_wr && WDATA[fei_pkg::BIT_READY] && !por_act
      |=> flags_reg[fei_pkg::BIT_READY] && cfg_reg[fei_pkg::BIT_READY])
      else $error("disabled source kept its flag");

   chk_int_assert: assert property (
      s_pending_on |=> !INT_OE_N)
      else $error("pin not pulled for pending event");

   chk_int_release: assert property (
      cfg_reg[fei_pkg::BIT_OUT_EN] || !(|pending) || por_act
      |=> INT_OE_N)
      else $error("pin pulled with nothing pending");

   chk_flag_fall: assert property (
      $fell(flags_reg[fei_pkg::BIT_ECC1]) |-> $past(EVT_ECC1))
      else $error("flag lowered without an event");

   chk_por_values: assert property (
      por_act |=> cfg_reg == fei_pkg::CFG_RST
                  && flags_reg == fei_pkg::FLAGS_POR_RST ##1 INT_OE_N)
      else $error("power-on values wrong");

   chk_por_flag_hold: assert property (
      !flags_reg[fei_pkg::BIT_POR] && !flags_wr && !cfg_wr
      |=> !flags_reg[fei_pkg::BIT_POR])
      else $error("power-on flag rose without a write");

   chk_rsvd_ones: assert property (
      (cfg_reg | fei_pkg::CFG_WR_MASK) == 16'hFFFF
      && (flags_reg | fei_pkg::FLAGS_WR_MASK) == 16'hFFFF)
      else $error("reserved bit not one");

endmodule

// ==== verification/fei_host_model.sv ====
// Host interrupt input: open-drain line with an external pull-up
`timescale 1ns/1ps
module fei_host_model (
   input  wire logic int_o,
   input  wire logic int_oe_n,
   output logic      pin
);
   // The pull-up sets the level whenever the device lets go of the line
   assign pin = int_oe_n ? 1'b1 : int_o;
endmodule

// ==== verification/flash_event_interrupt_unit_test.sv ====
// Self-checking bench for the flash event interrupt unit
`timescale 1ns/1ps
module flash_event_interrupt_unit_test;
   logic        ref_clk;
   logic        rst_n;
   logic        por_n;
   logic [2:0]  evt;
   logic [3:0]  addr;
   logic [15:0] wdata;
   logic        wr_s;
   logic        rd_s;
   logic [15:0] rdata;
   logic        int_o;
   logic        int_oe_n;
   logic        irq;
   logic        pin;
   logic [15:0] v;
   int          miscompares;
   int          samples_checked;

   fei_top u_dut (.REF_CLK(ref_clk), .RST_N(rst_n), .POR_N(por_n),
      .EVT_READY(evt[2]), .EVT_ECC2(evt[1]), .EVT_ECC1(evt[0]),
      .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata),
      .INT_O(int_o), .INT_OE_N(int_oe_n), .IRQ(irq));
   fei_host_model u_host (.int_o(int_o), .int_oe_n(int_oe_n), .pin(pin));

   always #50 ref_clk = ~ref_clk;

   task automatic end_sim();
      if (miscompares == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge ref_clk);
      wr_s <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge ref_clk);
      rd_s <= 1'b0;
      #10 d = rdata;
   endtask

   // One-cycle event pulse, then time for flag and pin to settle
   task automatic ev(input int s);
      @(posedge ref_clk);
      evt[s] <= 1'b1;
      @(posedge ref_clk);
      evt[s] <= 1'b0;
      repeat (3) @(posedge ref_clk);
      #10;
   endtask

   task automatic t_reset();
      rd(fei_pkg::ADDR_CFG, v);
      chk(v, 16'hFFFF);
      rd(fei_pkg::ADDR_FLAGS, v);
      chk(v, 16'hFFFF);
      rd(4'h7, v);
      chk(v, 16'h0000);
      chk({15'h0000, pin}, 16'h0001);
      wr(fei_pkg::ADDR_SYS_MASK, 16'h0001);
   endtask

   // Each source in turn, released by a different method
   task automatic t_sources();
      logic [15:0] m;
      for (int s = 0; s < 3; s++) begin
         m = 16'h0001 << ((s == 2) ? fei_pkg::BIT_READY : s);
         wr(fei_pkg::ADDR_CFG, 16'h7FFF & ~m);
         ev(s);
         chk({15'h0000, pin}, 16'h0000);
         chk({15'h0000, irq}, 16'h0001);
         rd(fei_pkg::ADDR_FLAGS, v);
         chk(v, 16'hFFFF ^ m);
         rd(fei_pkg::ADDR_SYS_ST, v);
         chk(v, 16'h0001);
         repeat (2) @(posedge ref_clk);
         #10 chk({15'h0000, irq}, 16'h0000);
         if (s == 0) begin
            wr(fei_pkg::ADDR_FLAGS, 16'h0000);
            rd(fei_pkg::ADDR_FLAGS, v);
            chk(v, 16'hFFFE);
            wr(fei_pkg::ADDR_FLAGS, m);
         end else if (s == 1) begin
            wr(fei_pkg::ADDR_CFG, 16'h7FFF);
         end else begin
            wr(fei_pkg::ADDR_CFG, 16'hFFFF & ~m);
         end
         repeat (2) @(posedge ref_clk);
         #10 chk({15'h0000, pin}, 16'h0001);
         rd(fei_pkg::ADDR_FLAGS, v);
         chk(v, 16'hFFFF);
      end
   endtask

   task automatic t_global();
      wr(fei_pkg::ADDR_CFG, 16'h8000);
      ev(1);
      chk({15'h0000, pin}, 16'h0001);
      rd(fei_pkg::ADDR_FLAGS, v);
      chk(v, 16'hFFFD);
      wr(fei_pkg::ADDR_CFG, 16'h0000);
      repeat (3) @(posedge ref_clk);
      #10 chk({15'h0000, pin}, 16'h0000);
      wr(fei_pkg::ADDR_FLAGS, 16'hFFFF);
      repeat (2) @(posedge ref_clk);
      #10 chk({15'h0000, pin}, 16'h0001);
   endtask

   task automatic t_por();
      @(posedge ref_clk);
      por_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      por_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rd(fei_pkg::ADDR_FLAGS, v);
      chk(v, 16'hFFFB);
      rd(fei_pkg::ADDR_CFG, v);
      chk(v, 16'hFFFF);
      wr(fei_pkg::ADDR_CFG, 16'h0000);
      repeat (3) @(posedge ref_clk);
      #10 chk({15'h0000, pin}, 16'h0001);
      rd(fei_pkg::ADDR_SYS_ST, v);
      chk(v, 16'h0003);
      wr(fei_pkg::ADDR_FLAGS, 16'h0004);
      rd(fei_pkg::ADDR_FLAGS, v);
      chk(v, 16'hFFFF);
   endtask

   // Power-on flag left low, then a hardware reset in mid-run
   task automatic t_hw_reset();
      @(posedge ref_clk);
      por_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      por_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rd(fei_pkg::ADDR_FLAGS, v);
      chk(v, 16'hFFFB);
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(fei_pkg::ADDR_FLAGS, v);
      chk(v, 16'hFFFF);
      rd(fei_pkg::ADDR_CFG, v);
      chk(v, 16'hFFFF);
      chk({15'h0000, pin}, 16'h0001);
   endtask

   initial begin
      ref_clk = 1'b0;
      rst_n = 1'b0;
      por_n = 1'b1;
      evt = 3'h0;
      addr = 4'h0;
      wdata = 16'h0000;
      wr_s = 1'b0;
      rd_s = 1'b0;
      miscompares = 0;
      samples_checked = 0;
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_reset();
      t_sources();
      t_global();
      t_por();
      t_hw_reset();
      end_sim();
   end

   // Whole run takes under 150 cycles; far beyond that means a hang
   initial begin
      #1000000;
      miscompares++;
      end_sim();
   end
endmodule
